// *** reload_timer_channel.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "reload_timer_regs.svh"

module reload_timer_channel
    import reload_timer_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       sel_in,
    input  wire sfr_wr_s    bus_in,
    input  wire logic       tick12_in,
    input  wire timer_src_s src_in,
    output logic [7:0]      control_out,
    output logic [15:0]     count_out,
    output logic [15:0]     reload_out,
    output logic            irq_out
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic        ovf_r;
    logic [1:0]  cks_r;
    logic        ie_r;
    logic        run_r;
    logic [1:0]  gate_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] reload_r;
    logic [1:0]  pin_sync_r;
    logic [1:0]  ext_sync_r;
    logic        pin_prev_r;
    logic        ext_prev_r;
    logic        tick;
    logic        gate_ok;
    logic        inc;
    logic        wrap;
    logic        wr_ctl;

    assign wr_ctl = sel_in && bus_in.wr && (bus_in.addr == `OFS_CONTROL);

    // ----------------------------------------------------------------
    // external input synchronisers; edge detect reads stage two only
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pin_sync_r <= 2'h0;
            ext_sync_r <= 2'h0;
            pin_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end
        else
        begin
            pin_sync_r <= {pin_sync_r[0], src_in.pin};
            ext_sync_r <= {ext_sync_r[0], src_in.ext_input};
            pin_prev_r <= pin_sync_r[1];
            ext_prev_r <= ext_sync_r[1];
        end
    end

    // ----------------------------------------------------------------
    // count source and gating
    // ----------------------------------------------------------------
    always_comb
    begin
        case (clk_sel_e'(cks_r))
            CKS_DIV12: tick = tick12_in;
            CKS_PIN:   tick = pin_prev_r && !pin_sync_r[1];
            CKS_SYS:   tick = 1'b1;
            CKS_EXT:   tick = ext_prev_r && !ext_sync_r[1];
            default:   tick = 1'b0;
        endcase
    end

    always_comb
    begin
        case (gate_sel_e'(gate_r))
            GATE_OFF:  gate_ok = 1'b1;
            GATE_IRQX: gate_ok = src_in.gate_irqx;
            GATE_IRQ2: gate_ok = src_in.gate_irq2;
            GATE_KBD:  gate_ok = src_in.gate_kbd;
            default:   gate_ok = 1'b0;
        endcase
    end

    assign inc  = run_r && gate_ok && tick;
    assign wrap = inc && (count_r == 16'hFFFF);

    // ----------------------------------------------------------------
    // control register; overflow set beats software clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ovf_r  <= 1'b0;
            cks_r  <= 2'h0;
            ie_r   <= 1'b0;
            run_r  <= 1'b0;
            gate_r <= 2'h0;
        end
        else
        begin
            if (wrap)
                ovf_r <= 1'b1;
            else if (wr_ctl && !bus_in.data[`BIT_OVF])
                ovf_r <= 1'b0;
            if (wr_ctl)
            begin
                cks_r  <= bus_in.data[`BIT_CKS_HI:`BIT_CKS_LO];
                ie_r   <= bus_in.data[`BIT_IE];
                run_r  <= bus_in.data[`BIT_RUN];
                gate_r <= bus_in.data[`BIT_GATE_HI:`BIT_GATE_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // count and reload; a byte write wins over counting for the written byte that cycle, the other byte still counts
    // ----------------------------------------------------------------
    always_comb
    begin
        count_nxt = count_r;
        if (wrap)
            count_nxt = reload_r;
        else if (inc)
            count_nxt = count_r + 16'h0001;
        if (sel_in && bus_in.wr && bus_in.addr == `OFS_COUNT_LOW)
            count_nxt[7:0] = bus_in.data;
        if (sel_in && bus_in.wr && bus_in.addr == `OFS_COUNT_HIGH)
            count_nxt[15:8] = bus_in.data;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            count_r <= {`RST_BYTE, `RST_BYTE};
        else
            count_r <= count_nxt;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            reload_r <= {`RST_BYTE, `RST_BYTE};
        else
        begin
            if (sel_in && bus_in.wr && bus_in.addr == `OFS_RELOAD_LOW)
                reload_r[7:0] <= bus_in.data;
            if (sel_in && bus_in.wr && bus_in.addr == `OFS_RELOAD_HIGH)
                reload_r[15:8] <= bus_in.data;
        end
    end

    assign control_out = {ovf_r, 1'b0, cks_r, ie_r, run_r, gate_r};
    assign count_out   = count_r;
    assign reload_out  = reload_r;
    assign irq_out     = ovf_r && ie_r;

endmodule

`default_nettype wire

// *** reload_timer_regs.svh ***
`ifndef RELOAD_TIMER_REGS_SVH
`define RELOAD_TIMER_REGS_SVH

// ----------------------------------------------------------------
// register offsets (special-function bus; timer picked by page)
// ----------------------------------------------------------------
`define OFS_CONTROL      8'hC8
`define OFS_RELOAD_LOW   8'hCA
`define OFS_RELOAD_HIGH  8'hCB
`define OFS_COUNT_LOW    8'hCC
`define OFS_COUNT_HIGH   8'hCD
`define PAGE_TIMER_A     4'h3
`define PAGE_TIMER_B     4'h4

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define BIT_OVF          7
`define BIT_RSVD         6
`define BIT_CKS_HI       5
`define BIT_CKS_LO       4
`define BIT_IE           3
`define BIT_RUN          2
`define BIT_GATE_HI      1
`define BIT_GATE_LO      0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RST_BYTE         8'h00
`define PRESCALE_DIV     4'hC
`define PRESCALE_LAST    4'hB

`endif

// *** reload_timer_pkg.sv ***
`default_nettype none
package reload_timer_pkg;

    typedef enum logic [1:0] {
        CKS_DIV12 = 2'b00,
        CKS_PIN   = 2'b01,
        CKS_SYS   = 2'b10,
        CKS_EXT   = 2'b11
    } clk_sel_e;

    typedef enum logic [1:0] {
        GATE_OFF  = 2'b00,
        GATE_IRQX = 2'b01,
        GATE_IRQ2 = 2'b10,
        GATE_KBD  = 2'b11
    } gate_sel_e;

    // per-timer event sources presented to one channel
    typedef struct packed {
        logic pin;
        logic ext_input;
        logic gate_irqx;
        logic gate_irq2;
        logic gate_kbd;
    } timer_src_s;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } sfr_wr_s;

endpackage

`default_nettype wire

// *** dual_reload_timer_pair.sv ***
// Summary of operation
// - timer a overflow sets sticky flag
// - timer a source: div12, pin, clock, ext
// - timer a enable gates flag onto irq
// - timer a counts only while run set
// - timer a gate: off, irq0, irq2, keypad
// - timer b flag set, cleared by zero
// - timer b source: div12, pin, clock, ext
// - timer b enable gates flag onto irq
// - timer b counts only while run set
// - timer b gate: off, irq1, irq2, keypad
// - count bytes readable, writable, reset zero
// - reload bytes readable, writable, reset zero
// - overflow reloads count from reload bytes
// - timer a doubles as transfer count
// - timer b doubles as address pointer
`timescale 1ns/10ps
`default_nettype none
`include "reload_timer_regs.svh"

module dual_reload_timer_pair
    import reload_timer_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic [3:0]  SFR_PAGE_IN,
    input  wire logic [7:0]  SFR_ADDR_IN,
    input  wire logic        SFR_WR_IN,
    input  wire logic [7:0]  SFR_WDATA_IN,
    output logic [7:0]       SFR_RDATA_OUT,
    output logic             SFR_HIT_OUT,
    input  wire logic        TIMER_A_PIN_IN,
    input  wire logic        TIMER_B_PIN_IN,
    input  wire logic        TIMER_C_EXTERNAL_INPUT_IN,
    input  wire logic        TIMER_D_EXTERNAL_INPUT_IN,
    input  wire logic        EXT_IRQ0_EVENT_IN,
    input  wire logic        EXT_IRQ1_EVENT_IN,
    input  wire logic        EXT_IRQ2_EVENT_IN,
    input  wire logic        KEYPAD_IRQ_EVENT_IN,
    output logic             SHARED_IRQ_OUT,
    output logic [15:0]      TRANSFER_COUNT_OUT,
    output logic [15:0]      TRANSFER_BASE_COUNT_OUT,
    output logic [15:0]      MEMORY_ADDRESS_OUT,
    output logic [15:0]      MEMORY_BASE_ADDRESS_OUT
);

    // ----------------------------------------------------------------
    // shared divide-by-twelve prescaler
    // ----------------------------------------------------------------
    logic [3:0]  presc_r;
    logic        tick12;
    sfr_wr_s     bus;
    timer_src_s  src_a;
    timer_src_s  src_b;
    logic        sel_a;
    logic        sel_b;
    logic [7:0]  ctl_a;
    logic [7:0]  ctl_b;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [15:0] rld_a;
    logic [15:0] rld_b;
    logic        irq_a;
    logic        irq_b;
    logic [7:0]  rdata_r;
    logic        hit_r;
    logic [15:0] rd_cnt;
    logic [15:0] rd_rld;
    logic [7:0]  rd_ctl;

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_N_IN)
            presc_r <= 4'h0;
        else if (presc_r == `PRESCALE_LAST)
            presc_r <= 4'h0;
        else
            presc_r <= presc_r + 4'h1;
    end

    assign tick12 = (presc_r == `PRESCALE_LAST);

    // ----------------------------------------------------------------
    // channel instances; page picks which timer a shared offset hits
    // ----------------------------------------------------------------
    assign bus   = '{wr: SFR_WR_IN, addr: SFR_ADDR_IN, data: SFR_WDATA_IN};
    assign sel_a = (SFR_PAGE_IN == `PAGE_TIMER_A);
    assign sel_b = (SFR_PAGE_IN == `PAGE_TIMER_B);

    assign src_a = '{pin: TIMER_A_PIN_IN, ext_input: TIMER_C_EXTERNAL_INPUT_IN,
                     gate_irqx: EXT_IRQ0_EVENT_IN, gate_irq2: EXT_IRQ2_EVENT_IN,
                     gate_kbd: KEYPAD_IRQ_EVENT_IN};
    assign src_b = '{pin: TIMER_B_PIN_IN, ext_input: TIMER_D_EXTERNAL_INPUT_IN,
                     gate_irqx: EXT_IRQ1_EVENT_IN, gate_irq2: EXT_IRQ2_EVENT_IN,
                     gate_kbd: KEYPAD_IRQ_EVENT_IN};

    reload_timer_channel u_timer_a (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .sel_in      (sel_a),
        .bus_in      (bus),
        .tick12_in   (tick12),
        .src_in      (src_a),
        .control_out (ctl_a),
        .count_out   (cnt_a),
        .reload_out  (rld_a),
        .irq_out     (irq_a)
    );

    reload_timer_channel u_timer_b (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .sel_in      (sel_b),
        .bus_in      (bus),
        .tick12_in   (tick12),
        .src_in      (src_b),
        .control_out (ctl_b),
        .count_out   (cnt_b),
        .reload_out  (rld_b),
        .irq_out     (irq_b)
    );

    // ----------------------------------------------------------------
    // read mux, registered so data outputs come from flip-flops
    // ----------------------------------------------------------------
    assign rd_cnt = sel_b ? cnt_b : cnt_a;
    assign rd_rld = sel_b ? rld_b : rld_a;
    assign rd_ctl = sel_b ? ctl_b : ctl_a;

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            rdata_r <= 8'h00;
            hit_r   <= 1'b0;
        end
        else
        begin
            hit_r   <= 1'b0;
            rdata_r <= 8'h00;
            if (sel_a || sel_b)
            begin
                hit_r <= 1'b1;
                case (SFR_ADDR_IN)
                    `OFS_CONTROL:     rdata_r <= rd_ctl;
                    `OFS_RELOAD_LOW:  rdata_r <= rd_rld[7:0];
                    `OFS_RELOAD_HIGH: rdata_r <= rd_rld[15:8];
                    `OFS_COUNT_LOW:   rdata_r <= rd_cnt[7:0];
                    `OFS_COUNT_HIGH:  rdata_r <= rd_cnt[15:8];
                    default:          hit_r <= 1'b0;
                endcase
            end
        end
    end

    assign SFR_RDATA_OUT = rdata_r;
    assign SFR_HIT_OUT   = hit_r;
    // both timers share the vector with the dma engine, so just or them
    assign SHARED_IRQ_OUT = irq_a || irq_b;

    // ----------------------------------------------------------------
    // dma views; dma must only use these after software stops the timers
    // ----------------------------------------------------------------
    assign TRANSFER_COUNT_OUT      = cnt_a;
    assign TRANSFER_BASE_COUNT_OUT = rld_a;
    assign MEMORY_ADDRESS_OUT      = cnt_b;
    assign MEMORY_BASE_ADDRESS_OUT = rld_b;

endmodule

`default_nettype wire

// *** dual_reload_timer_pair_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// --------------------------------
// port checks on timer a and bus
// --------------------------------
module dual_reload_timer_pair_asserts (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic [3:0]  SFR_PAGE_IN,
    input wire logic [7:0]  SFR_ADDR_IN,
    input wire logic        SFR_WR_IN,
    input wire logic [7:0]  SFR_WDATA_IN,
    input wire logic [7:0]  SFR_RDATA_OUT,
    input wire logic        SFR_HIT_OUT,
    input wire logic        SHARED_IRQ_OUT,
    input wire logic [15:0] TRANSFER_COUNT_OUT,
    input wire logic [15:0] TRANSFER_BASE_COUNT_OUT
);
    logic a_sel;
    logic map;
    logic [15:0] cnt;
    assign a_sel = SFR_PAGE_IN == 4'h3;
    assign map = (SFR_PAGE_IN inside {4'h3, 4'h4}) && (SFR_ADDR_IN inside {8'hC8, [8'hCA:8'hCD]});
    assign cnt = TRANSFER_COUNT_OUT;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence s_wr(a);
        SFR_WR_IN && a_sel && SFR_ADDR_IN == a;
    endsequence
    property p_hit; map |=> SFR_HIT_OUT; endproperty
    property p_miss; !map |=> !SFR_HIT_OUT && SFR_RDATA_OUT == 8'h00; endproperty
    property p_rsvd; a_sel && SFR_ADDR_IN == 8'hC8 |=> !SFR_RDATA_OUT[6]; endproperty
    property p_rd; a_sel && SFR_ADDR_IN == 8'hCC |=> SFR_RDATA_OUT == $past(cnt[7:0]); endproperty
    property p_rl; s_wr(8'hCA) |=> TRANSFER_BASE_COUNT_OUT[7:0] == $past(SFR_WDATA_IN); endproperty
    property p_rh; s_wr(8'hCB) |=> TRANSFER_BASE_COUNT_OUT[15:8] == $past(SFR_WDATA_IN); endproperty
    property p_ch; s_wr(8'hCD) |=> cnt[15:8] == $past(SFR_WDATA_IN); endproperty
    property p_keep;
        !(SFR_WR_IN && a_sel && SFR_ADDR_IN[7:1] == 7'h65) |=> $stable(TRANSFER_BASE_COUNT_OUT);
    endproperty
    // wrap to zero instead of reload must not slip through the +1 branch
    property p_step;
        !(SFR_WR_IN && a_sel && SFR_ADDR_IN[7:1] == 7'h66) |=> cnt == $past(cnt)
            || ($past(cnt) != 16'hFFFF && cnt == $past(cnt) + 16'h0001)
            || ($past(cnt) == 16'hFFFF && cnt == $past(TRANSFER_BASE_COUNT_OUT));
    endproperty
    property p_irq0; $rose(RST_N_IN) |-> !SHARED_IRQ_OUT; endproperty
    a_hit:  assert property (p_hit)  else $error("mapped access gave no hit");
    a_miss: assert property (p_miss) else $error("unmapped access answered");
    a_rsvd: assert property (p_rsvd) else $error("reserved control bit read one");
    a_rd:   assert property (p_rd)   else $error("count low read mismatch");
    a_rl:   assert property (p_rl)   else $error("reload low not written");
    a_rh:   assert property (p_rh)   else $error("reload high not written");
    a_ch:   assert property (p_ch)   else $error("count high not written");
    a_keep: assert property (p_keep) else $error("reload changed unwritten");
    a_step: assert property (p_step) else $error("count step illegal");
    a_irq0: assert property (p_irq0) else $error("request after reset");
endmodule
bind dual_reload_timer_pair dual_reload_timer_pair_asserts chk (.*);
`default_nettype wire

// *** dual_reload_timer_pair_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------
// timer pair bench
// ------------------
module dual_reload_timer_pair_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  page = 4'h0;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [3:0]  pins = 4'hF;
    logic [3:0]  ev = 4'h0;
    logic [7:0]  rdata;
    logic        hit;
    logic        irq;
    logic [15:0] xc, xb, mc, mb;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #12.5 clk = ~clk;
    dual_reload_timer_pair dut (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .SFR_PAGE_IN(page), .SFR_ADDR_IN(addr),
        .SFR_WR_IN(wr), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata), .SFR_HIT_OUT(hit),
        .TIMER_A_PIN_IN(pins[0]), .TIMER_B_PIN_IN(pins[1]),
        .TIMER_C_EXTERNAL_INPUT_IN(pins[2]), .TIMER_D_EXTERNAL_INPUT_IN(pins[3]),
        .EXT_IRQ0_EVENT_IN(ev[0]), .EXT_IRQ1_EVENT_IN(ev[1]), .EXT_IRQ2_EVENT_IN(ev[2]),
        .KEYPAD_IRQ_EVENT_IN(ev[3]), .SHARED_IRQ_OUT(irq), .TRANSFER_COUNT_OUT(xc),
        .TRANSFER_BASE_COUNT_OUT(xb), .MEMORY_ADDRESS_OUT(mc), .MEMORY_BASE_ADDRESS_OUT(mb)
    );
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        if (n > 0)
            #1;
    endtask
    // strobe dropped a cycle apart so back-to-back calls never reassign it in one step
    task automatic wr_reg(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
        page = p;
        addr = a;
        wdata = d;
        wr = 1'b1;
        idle(1);
        wr = 1'b0;
        idle(1);
    endtask
    task automatic rd(input logic [3:0] p, input logic [7:0] a, output logic [15:0] v);
        page = p;
        addr = a;
        idle(1);
        v = {7'h00, hit, rdata};
    endtask
    task automatic setc(input logic [3:0] p, input logic [15:0] c);
        wr_reg(p, 8'hCC, c[7:0]);
        wr_reg(p, 8'hCD, c[15:8]);
    endtask
    task automatic getc(input logic [3:0] p, output logic [15:0] c);
        logic [15:0] v;
        rd(p, 8'hCD, v);
        c[15:8] = v[7:0];
        rd(p, 8'hCC, v);
        c[7:0] = v[7:0];
    endtask
    // counts n+2 edges; stop keeps flag by writing one to it
    task automatic run_for(input logic [3:0] p, input logic [7:0] ctl, input int n);
        wr_reg(p, 8'hC8, ctl);
        idle(n);
        wr_reg(p, 8'hC8, (ctl & 8'hFB) | 8'h80);
    endtask
    task automatic t_reset();
        logic [15:0] v;
        // a write on a page that holds no timer must leave both counts at zero
        wr_reg(4'h5, 8'hCC, 8'hFF);
        for (int p = 3; p < 5; p++)
            for (int a = 8'hC8; a < 8'hCE; a++)
                if (a != 8'hC9)
                begin
                    rd(4'(p), 8'(a), v);
                    chk("reset value", v, 16'h0100);
                end
        rd(4'h5, 8'hC8, v);
        chk("unmapped page", v, 16'h0000);
        rd(4'h3, 8'hC9, v);
        chk("unmapped offset", v, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_ovf();
        logic [15:0] v;
        logic [3:0]  p;
        for (int t = 0; t < 2; t++)
        begin
            p = 4'h3 + 4'(t);
            wr_reg(p, 8'hCA, 8'h34);
            wr_reg(p, 8'hCB, 8'h12);
            setc(p, 16'hFFFE);
            run_for(p, 8'h2C, 0);
            getc(p, v);
            chk("reloaded count", v, 16'h1234);
            chk("base out", t ? mb : xb, 16'h1234);
            chk("current out", t ? mc : xc, 16'h1234);
            idle(5);
            rd(p, 8'hC8, v);
            chk("flag set", v, 16'h01A8);
            chk("request", 16'(irq), 16'h0001);
            wr_reg(p, 8'hC8, 8'hA0);
            chk("masked", 16'(irq), 16'h0000);
            rd(p, 8'hC8, v);
            chk("flag kept", v, 16'h01A0);
            wr_reg(p, 8'hC8, 8'h60);
            rd(p, 8'hC8, v);
            chk("flag cleared", v, 16'h0120);
            getc(p, v);
            chk("held count", v, 16'h1234);
        end
        $display("test overflow done");
    endtask
    task automatic t_div12();
        logic [15:0] v;
        for (int p = 3; p < 5; p++)
        begin
            setc(4'(p), 16'h0000);
            run_for(4'(p), 8'h04, 46);
            getc(4'(p), v);
            chk("div12 count", v, 16'h0004);
        end
        $display("test prescale done");
    endtask
    task automatic t_pin();
        logic [15:0] v;
        for (int i = 0; i < 4; i++)
        begin
            setc(4'h3 + 4'(i % 2), 16'h0000);
            wr_reg(4'h3 + 4'(i % 2), 8'hC8, i < 2 ? 8'h14 : 8'h34);
            repeat (3)
            begin
                pins[i] = 1'b0;
                idle(3);
                pins[i] = 1'b1;
                idle(3);
            end
            idle(4);
            wr_reg(4'h3 + 4'(i % 2), 8'hC8, 8'h80);
            getc(4'h3 + 4'(i % 2), v);
            chk("edge count", v, 16'h0003);
        end
        $display("test pin done");
    endtask
    task automatic t_gate();
        logic [15:0] v;
        int          idx;
        for (int t = 0; t < 2; t++)
            for (int g = 1; g < 4; g++)
            begin
                idx = (g == 1) ? t : g;
                ev = ~(4'h1 << idx);
                setc(4'h3 + 4'(t), 16'h0000);
                run_for(4'h3 + 4'(t), 8'h24 | 8'(g), 10);
                getc(4'h3 + 4'(t), v);
                chk("gated off", v, 16'h0000);
                ev = 4'h1 << idx;
                setc(4'h3 + 4'(t), 16'h0000);
                run_for(4'h3 + 4'(t), 8'h24 | 8'(g), 10);
                getc(4'h3 + 4'(t), v);
                chk("gated on", v, 16'h000C);
            end
        ev = 4'h0;
        $display("test gate done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        idle(20);
        rst_n = 1'b1;
        t_reset();
        t_ovf();
        t_div12();
        t_pin();
        t_gate();
        end_sim();
    end
    initial
    begin
        #500000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
